//--- rtl/fsw_host.sv
// host controller that runs command sequences and status polls on a parallel flash
`timescale 1ns/1ps
// Function
// RULE1 - device flags failure on timing limit
// RULE2 - failure bit counts only while toggling
// RULE3 - device flags failure programming zero to one
// RULE4 - host writes reset after any failure
// RULE5 - window bit low until erase starts
// RULE6 - no window for whole chip erase
// RULE7 - window high ignores further sector cycles
// RULE8 - window low accepts another sector
// RULE9 - host checks window before and after add
// RULE10 - confirm acceptance by toggling before window
// RULE11 - low supply refuses all writes
// RULE12 - write needs select, write low, output high
// RULE13 - no command taken during power-up
// RULE14 - device powers up reading array
// RULE15 - short glitches start no write
// RULE16 - array changes need full unlock sequence
// RULE17 - inverted data bit while programming
// RULE18 - status bit inverts each busy read
// RULE19 - window lasts fixed time-out
// RULE20 - reset clears failure, aborts algorithm
module fsw_host (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  output fsw_pkg::fsw_pins_s            fl_pins,
  input  wire logic [fsw_pkg::FD_W-1:0] fl_dq_i
);

  ////////////////////////////////////////////////////////////////////////////
  // types and state
  typedef enum logic [2:0] {ST_IDLE, ST_WSET, ST_WLOW, ST_WREC, ST_RLOW, ST_NEXT} fsw_st_e;
  typedef enum logic [2:0] {PH_SEQ, PH_POLL, PH_CONF, PH_DQ3, PH_PRE, PH_POST, PH_RD} fsw_ph_e;

  fsw_st_e                   st_q, st_d;        // bus cycle state
  fsw_ph_e                   ph_q, ph_d;        // operation phase
  logic [2:0]                op_q, op_d;        // running operation
  logic [2:0]                step_q, step_d;    // command cycle index
  logic [2:0]                cnt_q, cnt_d;      // strobe timer
  logic [1:0]                rdn_q, rdn_d;      // reads in this phase, saturating
  logic                      prev6_q, prev6_d;  // alternating bit of previous read
  logic                      seen5_q, seen5_d;  // failure bit seen once
  logic [6:0]                stat_q, stat_d;    // status flags
  logic [fsw_pkg::FA_W-1:0]  addr_q, addr_d;    // software address
  logic [fsw_pkg::FD_W-1:0]  data_q, data_d;    // software data
  logic [fsw_pkg::FD_W-1:0]  rd_q, rd_d;        // last word read
  logic [fsw_pkg::FA_W-1:0]  wa_q, wa_d;        // cycle address
  logic [fsw_pkg::FD_W-1:0]  wd_q, wd_d;        // cycle data
  logic [fsw_pkg::FD_W-1:0]  lastwd_q, lastwd_d;// data of previous write cycle
  logic [31:0]               rdat_q, rdat_d;    // bus read data
  fsw_pkg::fsw_pins_s        pins_q, pins_d;    // registered pins
  logic [fsw_pkg::FD_W-1:0]  dq_sync;           // synchronised data bus
  logic                      tog;               // two reads differ in the alternating bit
  logic [2:0]                seq_len;           // command cycles of op
  logic [fsw_pkg::FA_W-1:0]  seq_a;             // address of current command cycle
  logic [fsw_pkg::FD_W-1:0]  seq_d;             // data of current command cycle

  ////////////////////////////////////////////////////////////////////////////
  // data bus synchroniser
  fsw_pin_sync #(.W(fsw_pkg::FD_W)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_i   (fl_dq_i),
    .sync_o  (dq_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command sequence table: unlock pair, then op words; add-sector and reset are one bare cycle
  always_comb begin
    seq_len = 3'd0;
    seq_a   = fsw_pkg::CA_1;
    seq_d   = fsw_pkg::D_UNL1;
    case (op_q)
      fsw_pkg::OP_PROGRAM: seq_len = 3'd4;                      // RULE16
      fsw_pkg::OP_SERASE,
      fsw_pkg::OP_CERASE:  seq_len = 3'd6;                      // RULE16
      fsw_pkg::OP_ADDSEC,
      fsw_pkg::OP_RESET:   seq_len = 3'd1;
      default:             seq_len = 3'd0;
    endcase
    // unlock cycles alternate 555/AA and 2AA/55
    if (step_q == 3'd1 || step_q == 3'd4) begin
      seq_a = fsw_pkg::CA_2;
      seq_d = fsw_pkg::D_UNL2;
    end else if (step_q == 3'd2) begin
      seq_d = (op_q == fsw_pkg::OP_PROGRAM) ? fsw_pkg::D_PROG : fsw_pkg::D_ERASE;
    end
    // final cycle carries the op word
    if (op_q == fsw_pkg::OP_PROGRAM && step_q == 3'd3) begin
      seq_a = addr_q;
      seq_d = data_q;
    end else if (op_q == fsw_pkg::OP_SERASE && step_q == 3'd5) begin
      seq_a = addr_q;
      seq_d = fsw_pkg::D_SECT;
    end else if (op_q == fsw_pkg::OP_CERASE && step_q == 3'd5) begin
      seq_d = fsw_pkg::D_CHIP;
    end else if (op_q == fsw_pkg::OP_ADDSEC) begin
      seq_a = addr_q;
      seq_d = fsw_pkg::D_SECT;
    end else if (op_q == fsw_pkg::OP_RESET) begin
      seq_a = fsw_pkg::CA_0;
      seq_d = fsw_pkg::D_RESET;
    end
  end

  // toggling means two consecutive reads disagree in the alternating bit
  assign tog = (rdn_q == 2'd2) && (rd_q[fsw_pkg::DQ_TOG] != prev6_q);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: software port, op sequencer and bus cycles
  always_comb begin
    st_d = st_q;  ph_d = ph_q;  op_d = op_q;  step_d = step_q;
    cnt_d = cnt_q;  rdn_d = rdn_q;  prev6_d = prev6_q;  seen5_d = seen5_q;
    stat_d = stat_q;  addr_d = addr_q;  data_d = data_q;  rd_d = rd_q;
    wa_d = wa_q;  wd_d = wd_q;  lastwd_d = lastwd_q;
    rdat_d = 32'h0000_0000;
    // register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        fsw_pkg::REG_CTRL:   rdat_d = {29'h0000_0000, op_q};
        fsw_pkg::REG_ADDR:   rdat_d = {13'h0000, addr_q};
        fsw_pkg::REG_DATA:   rdat_d = {16'h0000, data_q};
        fsw_pkg::REG_STATUS: rdat_d = {25'h000_0000, stat_q};
        fsw_pkg::REG_RDATA:  rdat_d = {16'h0000, rd_q};
        default:             rdat_d = 32'h0000_0000;
      endcase
    end
    case (st_q)
      ST_IDLE: begin
        // writes refused while busy; ADDR and DATA too
        if (reg_wr && reg_addr == fsw_pkg::REG_ADDR) begin
          addr_d = reg_wdata[fsw_pkg::FA_W-1:0];
        end else if (reg_wr && reg_addr == fsw_pkg::REG_DATA) begin
          data_d = reg_wdata[fsw_pkg::FD_W-1:0];
        end else if (reg_wr && reg_addr == fsw_pkg::REG_CTRL && reg_wdata[2:0] != 3'h0) begin
          op_d   = reg_wdata[2:0];
          step_d = 3'd0;
          rdn_d  = 2'd0;
          seen5_d = 1'b0;
          st_d   = ST_NEXT;
          stat_d = 7'h01;                                 // busy, all else clear
          case (reg_wdata[2:0])
            fsw_pkg::OP_READ:   ph_d = PH_RD;
            fsw_pkg::OP_POLL:   ph_d = PH_POLL;
            fsw_pkg::OP_ADDSEC: ph_d = PH_PRE;            // RULE9
            default:            ph_d = PH_SEQ;
          endcase
        end
      end
      ST_WSET: st_d = ST_WLOW;                            // RULE12
      ST_WLOW: begin
        // hold write strobe low for the least pulse time
        if (cnt_q == 3'd0) begin
          st_d = ST_WREC;
        end else begin
          cnt_d = cnt_q - 3'd1;
        end
      end
      ST_WREC: begin
        lastwd_d = wd_q;
        st_d     = ST_NEXT;
      end
      ST_RLOW: begin
        // sample after access time plus the three synchroniser stages
        if (cnt_q == 3'd0) begin
          prev6_d = rd_q[fsw_pkg::DQ_TOG];
          rd_d    = dq_sync;
          rdn_d   = (rdn_q == 2'd2) ? 2'd2 : rdn_q + 2'd1;
          st_d    = ST_NEXT;
        end else begin
          cnt_d = cnt_q - 3'd1;
        end
      end
      ST_NEXT: begin
        st_d  = ST_RLOW;                                  // most branches read again
        cnt_d = 3'(fsw_pkg::RD_CYC - 1);
        case (ph_q)
          PH_SEQ: begin
            if (step_q < seq_len) begin
              // issue whole sequence back to back
              wa_d   = seq_a;                             // RULE16
              wd_d   = seq_d;
              step_d = step_q + 3'd1;
              cnt_d  = 3'(fsw_pkg::WP_CYC - 1);
              st_d   = ST_WSET;
            end else begin
              rdn_d = 2'd0;
              case (op_q)
                fsw_pkg::OP_PROGRAM, fsw_pkg::OP_CERASE: ph_d = PH_POLL;
                fsw_pkg::OP_SERASE: ph_d = PH_CONF;       // RULE10
                fsw_pkg::OP_ADDSEC: ph_d = PH_POST;       // RULE9
                default: begin
                  st_d = ST_IDLE;
                  stat_d[fsw_pkg::ST_BUSY] = 1'b0;
                  stat_d[fsw_pkg::ST_DONE] = 1'b1;
                end
              endcase
            end
          end
          PH_POLL: begin
            if (rdn_q != 2'd2) begin
              // need two reads to compare
            end else if (!tog) begin
              st_d = ST_IDLE;
              stat_d[fsw_pkg::ST_BUSY] = 1'b0;
              stat_d[fsw_pkg::ST_DONE] = 1'b1;
            end else if (rd_q[fsw_pkg::DQ_FAIL]) begin
              // failure bit only believed while toggling
              if (seen5_q) begin                          // RULE2
                stat_d[fsw_pkg::ST_FAIL] = 1'b1;
                op_d   = fsw_pkg::OP_RESET;               // RULE4
                ph_d   = PH_SEQ;
                step_d = 3'd0;
                st_d   = ST_NEXT;
              end else begin
                seen5_d = 1'b1;
              end
            end
          end
          PH_CONF: begin
            if (rdn_q != 2'd2) begin
              // second read pending
            end else if (tog) begin
              stat_d[fsw_pkg::ST_ACCEPT] = 1'b1;
              ph_d  = PH_DQ3;                             // RULE10
              rdn_d = 2'd0;
            end else begin
              st_d = ST_IDLE;
              stat_d[fsw_pkg::ST_BUSY] = 1'b0;
              stat_d[fsw_pkg::ST_DONE] = 1'b1;
            end
          end
          PH_PRE: begin
            if (rdn_q == 2'd0) begin
              // window not yet read for this add: read it first
            end else if (rd_q[fsw_pkg::DQ_WIN]) begin
              // window closed: skip the add cycle
              st_d = ST_IDLE;                             // RULE9
              stat_d[fsw_pkg::ST_REJECT] = 1'b1;
              stat_d[fsw_pkg::ST_BUSY]   = 1'b0;
              stat_d[fsw_pkg::ST_DONE]   = 1'b1;
            end else begin
              ph_d = PH_SEQ;
              st_d = ST_NEXT;
            end
          end
          default: begin
            // DQ3, POST, RD: one read then finish
            if (rdn_q != 2'd0) begin
              st_d = ST_IDLE;
              stat_d[fsw_pkg::ST_BUSY] = 1'b0;
              stat_d[fsw_pkg::ST_DONE] = 1'b1;
              if (ph_q == PH_DQ3) begin
                stat_d[fsw_pkg::ST_ERASING] = rd_q[fsw_pkg::DQ_WIN];
              end
              if (ph_q == PH_POST) begin
                stat_d[fsw_pkg::ST_MAYBE] = rd_q[fsw_pkg::DQ_WIN];  // RULE9
              end
            end
          end
        endcase
        // first read of a phase entered from PH_SEQ or PH_CONF
        if (st_d == ST_RLOW && ph_d != ph_q) begin
          rdn_d = 2'd0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin values follow next state; write strobe only with select low and output high
  always_comb begin
    pins_d       = pins_q;
    pins_d.ce_n  = 1'b1;
    pins_d.we_n  = 1'b1;
    pins_d.oe_n  = 1'b1;
    pins_d.dq_oe = 1'b0;
    case (st_d)
      ST_WSET, ST_WREC: begin
        pins_d.ce_n  = 1'b0;
        pins_d.addr  = wa_d;
        pins_d.dq_o  = wd_d;
        pins_d.dq_oe = 1'b1;
      end
      ST_WLOW: begin
        pins_d.ce_n  = 1'b0;                              // RULE12
        pins_d.we_n  = 1'b0;
        pins_d.dq_oe = 1'b1;
      end
      ST_RLOW: begin
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        pins_d.addr = addr_q;
      end
      default: pins_d.dq_oe = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register everything
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;  ph_q <= PH_SEQ;  op_q <= 3'h0;  step_q <= 3'h0;
      cnt_q <= 3'h0;  rdn_q <= 2'h0;  prev6_q <= 1'b0;  seen5_q <= 1'b0;
      stat_q <= 7'h00;  addr_q <= 19'h0_0000;  data_q <= 16'h0000;
      rd_q <= 16'h0000;  wa_q <= 19'h0_0000;  wd_q <= 16'h0000;
      lastwd_q <= 16'h0000;  rdat_q <= 32'h0000_0000;
      pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 19'h0_0000,
                  dq_o: 16'h0000, dq_oe: 1'b0};
    end else begin
      st_q <= st_d;  ph_q <= ph_d;  op_q <= op_d;  step_q <= step_d;
      cnt_q <= cnt_d;  rdn_q <= rdn_d;  prev6_q <= prev6_d;  seen5_q <= seen5_d;
      stat_q <= stat_d;  addr_q <= addr_d;  data_q <= data_d;
      rd_q <= rd_d;  wa_q <= wa_d;  wd_q <= wd_d;
      lastwd_q <= lastwd_d;  rdat_q <= rdat_d;
      pins_q <= pins_d;
    end
  end

  assign reg_rdata = rdat_q;
  assign fl_pins   = pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_we_low;
    !pins_q.we_n && !pins_q.ce_n && pins_q.oe_n;
  endsequence
  sequence s_reset_word;
    !pins_q.we_n && pins_q.dq_o == fsw_pkg::D_RESET;
  endsequence

  AST_WE_GATED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
    !pins_q.we_n |-> s_we_low) else $error("write strobe low without select or with output low");
  AST_WE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
    $fell(pins_q.we_n) |-> ##1 (pins_q.we_n && !pins_q.ce_n) ##1 pins_q.ce_n)
    else $error("write pulse length or recovery wrong");
  AST_FAIL_ON_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
    $rose(stat_q[fsw_pkg::ST_FAIL]) |-> $past(tog) && $past(rd_q[fsw_pkg::DQ_FAIL]) && $past(seen5_q))
    else $error("failure reported without toggling");
  AST_FAIL_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
    $rose(stat_q[fsw_pkg::ST_FAIL]) |-> ##[1:4] s_reset_word)
    else $error("no reset command after failure");
  AST_PROG_UNLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE16
    (st_q == ST_WSET && (wd_q == fsw_pkg::D_PROG || wd_q == fsw_pkg::D_ERASE))
    |-> lastwd_q == fsw_pkg::D_UNL2) else $error("op word without unlock cycles");
  AST_ADD_RECHECK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
    (st_q == ST_WREC && op_q == fsw_pkg::OP_ADDSEC) |-> ##[1:4] !pins_q.oe_n)
    else $error("window not read after sector add");
  AST_CONF_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
    $rose(stat_q[fsw_pkg::ST_ACCEPT]) |-> $past(ph_q) == PH_CONF && $past(rdn_q) == 2'd2)
    else $error("window read before acceptance confirmed");
  AST_READ_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
    $fell(pins_q.oe_n) |-> (!pins_q.oe_n && pins_q.we_n)[*5] ##1 pins_q.oe_n)
    else $error("read strobe length wrong");

endmodule // fsw_host

//--- rtl/fsw_pin_sync.sv
// three-stage pin synchroniser with agreement filter, one per data bit
`timescale 1ns/1ps
module fsw_pin_sync #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q, s2_q, s3_q, out_q;   // stages and filtered output
      logic out_d;                      // next filtered value
      // take the third stage only once second and third agree
      always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
      end
      // register the stages
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q  <= pin_i[g];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          out_q <= out_d;
        end
      end
      assign sync_o[g] = out_q;
    end
  endgenerate

endmodule // fsw_pin_sync

//--- rtl/fsw_pkg.sv
// package: constants, register map, command words and pin bundle of the flash host
package fsw_pkg;

  // clock and bus-cycle timing
  localparam int CLK_NS     = 50;                               // sys_clk period
  localparam int T_WP_NS    = 35;                               // least write strobe low time
  localparam int T_ACC_NS   = 90;                               // least read access time
  localparam int SYNC_CYC   = 3;                                // pin synchroniser stages; the agreement filter adds one more cycle of latency
  localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;  // rounded up
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS; // rounded up
  localparam int RD_CYC     = ACC_CYC + SYNC_CYC;               // output strobe low time

  // widths
  localparam int FA_W = 19;                                     // word address width
  localparam int FD_W = 16;                                     // data bus width

  // software register indices
  localparam logic [3:0] REG_CTRL   = 4'h0;                     // op start / current op
  localparam logic [3:0] REG_ADDR   = 4'h1;                     // flash address
  localparam logic [3:0] REG_DATA   = 4'h2;                     // program data
  localparam logic [3:0] REG_STATUS = 4'h3;                     // status flags
  localparam logic [3:0] REG_RDATA  = 4'h4;                     // last word read

  // operation codes written to REG_CTRL
  localparam logic [2:0] OP_NONE    = 3'h0;
  localparam logic [2:0] OP_READ    = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_SERASE  = 3'h3;
  localparam logic [2:0] OP_ADDSEC  = 3'h4;
  localparam logic [2:0] OP_CERASE  = 3'h5;
  localparam logic [2:0] OP_POLL    = 3'h6;
  localparam logic [2:0] OP_RESET   = 3'h7;

  // status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_ERASING = 3;
  localparam int ST_REJECT  = 4;
  localparam int ST_MAYBE   = 5;
  localparam int ST_ACCEPT  = 6;

  // status bits on the flash data bus
  localparam int DQ_WIN  = 3;                                   // erase window
  localparam int DQ_FAIL = 5;                                   // timing limit
  localparam int DQ_TOG  = 6;                                   // alternating bit

  // command cycle addresses and data
  localparam logic [FA_W-1:0] CA_1    = 19'h0_0555;
  localparam logic [FA_W-1:0] CA_2    = 19'h0_02aa;
  localparam logic [FA_W-1:0] CA_0    = 19'h0_0000;
  localparam logic [FD_W-1:0] D_UNL1  = 16'h00aa;
  localparam logic [FD_W-1:0] D_UNL2  = 16'h0055;
  localparam logic [FD_W-1:0] D_PROG  = 16'h00a0;
  localparam logic [FD_W-1:0] D_ERASE = 16'h0080;
  localparam logic [FD_W-1:0] D_SECT  = 16'h0030;
  localparam logic [FD_W-1:0] D_CHIP  = 16'h0010;
  localparam logic [FD_W-1:0] D_RESET = 16'h00f0;

  // pin bundle toward the flash
  typedef struct packed {
    logic            ce_n;    // chip select
    logic            we_n;    // write strobe
    logic            oe_n;    // output strobe
    logic [FA_W-1:0] addr;    // address
    logic [FD_W-1:0] dq_o;    // data out
    logic            dq_oe;   // data out enable
  } fsw_pins_s;

endpackage

//--- verif/fsw_flash_model.sv
// behavioural parallel flash device that answers the host pins
`timescale 1ns/1ps
module fsw_flash_model #(
  parameter int WIN_NS   = 50000,  // sector erase window time-out
  parameter int BUSY_RDS = 8,      // status reads until an algorithm ends
  parameter int PWRUP_NS = 200     // supply ramp time, below supply_lockout_level
) (
  input  wire fsw_pkg::fsw_pins_s  pins,
  output logic [fsw_pkg::FD_W-1:0] dq
);
  logic [15:0] mem [int];          // array words, erased when absent
  logic [15:0] dout;               // word of the last read
  logic [15:0] pd;                 // word being programmed
  logic        arm;                // erase setup seen
  logic        pgm;                // program setup seen
  logic        tog;                // alternating status bit
  logic        fail;               // failure flag
  logic        low_supply;         // supply still below supply_lockout_level
  int          ul;                 // unlock step
  int          rds;                // reads since algorithm start
  int          mode;               // 0 read, 1 program, 2 sector erase, 3 chip erase
  realtime     t_win;              // last sector cycle time
  realtime     t_we;               // write strobe fall time
  initial begin
    mode = 0;
    ul = 0;
    arm = 0;
    pgm = 0;
    tog = 0;
    fail = 0;
    dout = 16'h0000;
    low_supply = 1'b1;
    #PWRUP_NS low_supply = 1'b0;
  end
  function automatic logic [15:0] word(int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // window high once the time-out has run
  function automatic logic win();
    return mode == 2 && ($realtime - t_win >= WIN_NS);
  endfunction
  always @(negedge pins.we_n) t_we = $realtime;
  ////////////////////////////////////////////////////////////////////////////////
  // write cycle taken at the rising write strobe
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.oe_n && $realtime - t_we >= 5) begin
      if (low_supply) begin
        // locked out: no command taken, back to array read
        mode = 0;
        ul = 0;
        pgm = 0;
        arm = 0;
      end else if (pins.dq_o == 16'h00f0) begin
        mode = 0;
        fail = 0;
        ul = 0;
      end else if (mode == 2 && !win() && pins.dq_o == 16'h0030) begin
        t_win = $realtime;
      end else if (mode != 0) begin
        ul = 0;
      end else if (pgm) begin
        pgm = 0;
        mode = 1;
        rds = 0;
        pd = pins.dq_o;
        fail = |(pd & ~word(int'(pins.addr)));
        mem[int'(pins.addr)] = word(int'(pins.addr)) & pd;
      end else if (ul < 2) begin
        ul = (pins.dq_o == (ul == 0 ? 16'h00aa : 16'h0055)) ? ul + 1 : 0;
      end else begin
        ul = 0;
        rds = 0;
        t_win = $realtime;
        pgm = pins.dq_o == 16'h00a0;
        if (arm && pins.dq_o == 16'h0030) mode = 2;
        if (arm && pins.dq_o == 16'h0010) mode = 3;
        arm = pins.dq_o == 16'h0080;
      end
    end
  end
  // read cycle: status while busy, array otherwise
  always @(negedge pins.oe_n) begin
    if (!pins.ce_n) begin
      if (mode == 0) begin
        dout = word(int'(pins.addr));
      end else begin
        tog = ~tog;
        dout = 16'h0000;
        dout[7] = (mode == 1) ? ~pd[7] : 1'b0;
        dout[6] = tog;
        dout[5] = fail;
        dout[3] = win();
        rds++;
        if (!fail && rds >= BUSY_RDS) mode = 0;
      end
    end
  end
  // released bus shows the inverse, never the stale word
  assign dq = (!pins.ce_n && !pins.oe_n) ? dout : ~dout;
endmodule // fsw_flash_model

//--- verif/fsw_host_bench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module fsw_host_bench;
  logic                   sys_clk;
  logic                   rst_n;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic [31:0]            reg_rdata;
  logic [31:0]            got;
  logic [15:0]            fl_dq_i;
  fsw_pkg::fsw_pins_s     fl_pins;
  int                     bad_count;
  int                     check_count;
  fsw_host fsw_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_pins(fl_pins), .fl_dq_i(fl_dq_i));
  fsw_flash_model fsw_flash_model_inst (.pins(fl_pins), .dq(fl_dq_i));
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // start one op, poll busy under a bound, compare status
  task automatic op(input logic [2:0] code, input logic [31:0] exp);
    int n;
    wr(fsw_pkg::REG_CTRL, {29'h0000_0000, code});
    n = 0;
    got = 32'h0000_0001;
    while (got[fsw_pkg::ST_BUSY] !== 1'b0 && n < 3000) begin
      rd(fsw_pkg::REG_STATUS, got);
      n++;
    end
    `CHK(got, exp)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(fsw_pkg::REG_STATUS, got);
    `CHK(got, 32'h0000_0000)
    `CHK({fl_pins.ce_n, fl_pins.we_n, fl_pins.oe_n, fl_pins.dq_oe}, 4'he)
    rd(4'h9, got);
    `CHK(got, 32'h0000_0000)
    wr(fsw_pkg::REG_ADDR, 32'h0000_000a);
    wr(fsw_pkg::REG_DATA, 32'h0000_1234);
    op(fsw_pkg::OP_PROGRAM, 32'h0000_0002);
    op(fsw_pkg::OP_READ, 32'h0000_0002);
    rd(fsw_pkg::REG_RDATA, got);
    `CHK(got, 32'h0000_1234)
    wr(fsw_pkg::REG_DATA, 32'h0000_ffff);
    op(fsw_pkg::OP_PROGRAM, 32'h0000_0006);
    op(fsw_pkg::OP_READ, 32'h0000_0002);
    rd(fsw_pkg::REG_RDATA, got);
    `CHK(got, 32'h0000_1234)
    wr(fsw_pkg::REG_ADDR, 32'h0000_8000);
    op(fsw_pkg::OP_SERASE, 32'h0000_0042);
    wr(fsw_pkg::REG_ADDR, 32'h0001_0000);
    op(fsw_pkg::OP_ADDSEC, 32'h0000_0002);
    repeat (1100) @(posedge sys_clk);
    op(fsw_pkg::OP_ADDSEC, 32'h0000_0012);
    op(fsw_pkg::OP_POLL, 32'h0000_0002);
    op(fsw_pkg::OP_CERASE, 32'h0000_0002);
    op(fsw_pkg::OP_RESET, 32'h0000_0002);
    final_report();
  end
endmodule // fsw_host_bench
